// file: core/mcs_mode_ctrl.sv
// operating mode control, register file and status pin logic
// assumes all comparator and pin inputs are synchronous to CLK and the register
// port is fed by the serial interface front end in the same clock domain
//
// Functional notes
// - enabled needs a pin high and supply ok
// - boost needs battery uvlo, others output uvlo
// - both pins low: shutdown, registers reset
// - no function enabled: standby, registers kept
// - register access whenever either pin high
// - shutdown and standby keep all switches open
// - boost enabled by pin and bit
// - charger enabled by pin and select 01
// - health discharge by pin and select 10
// - boost below wake, leave above 106 percent
// - status pin is open drain, low active
// - selection bits 3..7, reset selects boost active
// - any selected item pulls status low
// - bit 7 shows live boost active
// - bit 6 shows sticky boost entry alert
// - bit 5 shows sticky charge done alert
// - bit 4 shows thermal shutdown active
// - bit 3 shows thermistor range fault
// - thermal trip opens switches, restart on release
// - charging paused on thermistor hot or cold
// - spread spectrum dithers switching clock seven percent
// - select field at bits 6:5 of control
// - wake threshold programmable by register
`timescale 1ns/100ps
`default_nettype none
module mcs_mode_ctrl
  import mcs_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic BOOST_ENABLE_PIN,
  input wire logic CHARGE_ENABLE_PIN,
  input wire logic SUPPLY_OK,
  input wire logic BACKUP_UVLO_OK,
  input wire logic OUTPUT_UVLO_OK,
  input wire logic VOUT_BELOW_WAKE,
  input wire logic VOUT_ABOVE_STANDBY,
  input wire logic THERMAL_TRIP_CMP,
  input wire logic THERMISTOR_HOT,
  input wire logic THERMISTOR_COLD,
  input wire logic CHARGE_DONE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic I2C_ACTIVE,
  output logic BOOST_ON,
  output logic CHARGER_ON,
  output logic HEALTH_ON,
  output logic [7:0] BOOST_WAKE_THRESHOLD,
  output logic SWITCH_CLK,
  output logic STATUS_OUT,
  output logic STATUS_OE_N
);

  mcs_swclk_if swclk ();

  mcs_mode_e mode_r;
  mcs_mode_e mode_nxt;
  mcs_mode_e base_mode;
  logic [7:0] ctrl_r;
  logic [7:0] stsel_r;
  logic [7:0] wake_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] flags;
  logic i2c_active_r;
  logic boost_on_r;
  logic charger_on_r;
  logic health_on_r;
  logic thermal_r;
  logic entry_alert_r;
  logic done_alert_r;
  logic status_oe_n_r;
  logic pins_any;
  logic enabled;
  logic boost_en;
  logic charge_en;
  logic health_en;
  logic go_boost;
  logic temp_fault;
  logic reg_ok;
  logic flags_read;
  logic status_any;
  logic status_out_r;
  logic [7:3] status_items;
  wire logic [7:3] status_hit;

  assign pins_any = BOOST_ENABLE_PIN || CHARGE_ENABLE_PIN;
  assign enabled = pins_any && SUPPLY_OK;
  assign boost_en = BOOST_ENABLE_PIN && ctrl_r[MCS_CTRL_BOOST_BIT];
  assign charge_en = CHARGE_ENABLE_PIN &&
    (ctrl_r[MCS_CTRL_SEL_HI:MCS_CTRL_SEL_LO] == MCS_SEL_CHARGE);
  assign health_en = CHARGE_ENABLE_PIN &&
    (ctrl_r[MCS_CTRL_SEL_HI:MCS_CTRL_SEL_LO] == MCS_SEL_HEALTH);
  assign go_boost = boost_en && BACKUP_UVLO_OK && VOUT_BELOW_WAKE;
  assign temp_fault = THERMISTOR_HOT || THERMISTOR_COLD;
  assign reg_ok = pins_any;
  assign flags_read = reg_ok && REG_RD && (REG_ADDR == MCS_FLAGS_ADDR);

  // mode held while the output rail is healthy; output uvlo forces standby
  always_comb begin
    if (!OUTPUT_UVLO_OK) begin
      base_mode = MCS_MODE_STANDBY;
    end else if (charge_en) begin
      base_mode = MCS_MODE_CHARGE;
    end else if (health_en) begin
      base_mode = MCS_MODE_HEALTH;
    end else begin
      base_mode = MCS_MODE_STANDBY;
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    if (!enabled) begin
      mode_nxt = MCS_MODE_SHUTDOWN;
    end else if (THERMAL_TRIP_CMP) begin
      mode_nxt = MCS_MODE_THERMAL;
    end else begin
      unique case (mode_r)
        MCS_MODE_SHUTDOWN, MCS_MODE_THERMAL: begin
          mode_nxt = MCS_MODE_STANDBY;
        end
        MCS_MODE_BOOST: begin
          if (!boost_en || !BACKUP_UVLO_OK || VOUT_ABOVE_STANDBY) begin
            mode_nxt = base_mode;
          end
        end
        MCS_MODE_STANDBY, MCS_MODE_CHARGE, MCS_MODE_HEALTH: begin
          mode_nxt = go_boost ? MCS_MODE_BOOST : base_mode;
        end
        default: begin
          mode_nxt = MCS_MODE_SHUTDOWN;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_r <= MCS_MODE_SHUTDOWN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // power switch enables; every other mode leaves all switches open
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      boost_on_r <= 1'b0;
      charger_on_r <= 1'b0;
      health_on_r <= 1'b0;
      thermal_r <= 1'b0;
    end else begin
      boost_on_r <= (mode_nxt == MCS_MODE_BOOST);
      charger_on_r <= (mode_nxt == MCS_MODE_CHARGE) && !temp_fault;
      health_on_r <= (mode_nxt == MCS_MODE_HEALTH);
      thermal_r <= (mode_nxt == MCS_MODE_THERMAL);
    end
  end

  // register file; both pins low returns every register to its default
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r <= MCS_CTRL_RESET;
      stsel_r <= MCS_STSEL_RESET;
      wake_r <= MCS_WAKE_RESET;
    end else if (!pins_any) begin
      ctrl_r <= MCS_CTRL_RESET;
      stsel_r <= MCS_STSEL_RESET;
      wake_r <= MCS_WAKE_RESET;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        MCS_CTRL_ADDR: begin
          ctrl_r <= REG_WDATA;
        end
        MCS_STSEL_ADDR: begin
          stsel_r <= {REG_WDATA[7:3], 3'h0};
        end
        MCS_WAKE_ADDR: begin
          wake_r <= REG_WDATA;
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // sticky alerts: a new event wins over the clearing read
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      entry_alert_r <= 1'b0;
    end else if (!pins_any) begin
      entry_alert_r <= 1'b0;
    end else if (mode_nxt == MCS_MODE_BOOST && mode_r != MCS_MODE_BOOST) begin
      entry_alert_r <= 1'b1;
    end else if (flags_read) begin
      entry_alert_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      done_alert_r <= 1'b0;
    end else if (!pins_any) begin
      done_alert_r <= 1'b0;
    end else if (CHARGE_DONE) begin
      done_alert_r <= 1'b1;
    end else if (flags_read) begin
      done_alert_r <= 1'b0;
    end
  end

  assign flags = {boost_on_r, entry_alert_r, done_alert_r, thermal_r, temp_fault, mode_r};

  always_comb begin
    unique case (REG_ADDR)
      MCS_CTRL_ADDR: rdata_nxt = ctrl_r;
      MCS_STSEL_ADDR: rdata_nxt = stsel_r;
      MCS_WAKE_ADDR: rdata_nxt = wake_r;
      MCS_FLAGS_ADDR: rdata_nxt = flags;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      i2c_active_r <= 1'b0;
    end else begin
      i2c_active_r <= pins_any;
    end
  end

  // read data holds until the next read and reads zero while the port is off
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r <= 8'h00;
    end else if (!reg_ok) begin
      rdata_r <= 8'h00;
    end else if (REG_RD) begin
      rdata_r <= rdata_nxt;
    end
  end

  // status pin: low if any selected item is asserted
  assign status_items = {
    boost_on_r,
    entry_alert_r,
    done_alert_r,
    thermal_r,
    temp_fault
  };

  // one gate per selectable item, indexed by its select bit
  for (genvar i = MCS_INC_TEMP_FAULT; i <= MCS_INC_BOOST_ACTIVE; i++) begin : g_status
    assign status_hit[i] = stsel_r[i] && status_items[i];
  end

  assign status_any = |status_hit;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_oe_n_r <= 1'b1;
    end else begin
      status_oe_n_r <= !status_any;
    end
  end

  // open-drain data: the pin is only ever pulled low, never driven high
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_out_r <= 1'b0;
    end else begin
      status_out_r <= 1'b0;
    end
  end

  assign swclk.run = boost_on_r || charger_on_r || health_on_r;
  assign swclk.spread_en = ctrl_r[MCS_CTRL_SPREAD_BIT];

  mcs_swclk_gen u_swclk (
    .clk(CLK),
    .rst_n(RESETN),
    .sw(swclk.gen)
  );

  assign REG_RDATA = rdata_r;
  assign I2C_ACTIVE = i2c_active_r;
  assign BOOST_ON = boost_on_r;
  assign CHARGER_ON = charger_on_r;
  assign HEALTH_ON = health_on_r;
  assign BOOST_WAKE_THRESHOLD = wake_r;
  assign SWITCH_CLK = swclk.sw_clk;
  assign STATUS_OUT = status_out_r;
  assign STATUS_OE_N = status_oe_n_r;

endmodule : mcs_mode_ctrl
`default_nettype wire

// file: core/mcs_pkg.sv
// mode control and status package: register map, field positions, reset values, timing
// assumes a 40 MHz system clock and an 8-bit register access port
package mcs_pkg;

  // register offsets
  localparam logic [7:0] MCS_WAKE_ADDR = 8'h0A;
  localparam logic [7:0] MCS_CTRL_ADDR = 8'h0B;
  localparam logic [7:0] MCS_STSEL_ADDR = 8'h0D;
  localparam logic [7:0] MCS_FLAGS_ADDR = 8'h0E;

  // control register fields
  localparam int MCS_CTRL_BOOST_BIT = 7;
  localparam int MCS_CTRL_SEL_HI = 6;
  localparam int MCS_CTRL_SEL_LO = 5;
  localparam int MCS_CTRL_SPREAD_BIT = 4;
  localparam logic [1:0] MCS_SEL_NONE = 2'h0;
  localparam logic [1:0] MCS_SEL_CHARGE = 2'h1;
  localparam logic [1:0] MCS_SEL_HEALTH = 2'h2;

  // status pin item selection fields
  localparam int MCS_INC_BOOST_ACTIVE = 7;
  localparam int MCS_INC_BOOST_ENTRY = 6;
  localparam int MCS_INC_DONE = 5;
  localparam int MCS_INC_THERMAL = 4;
  localparam int MCS_INC_TEMP_FAULT = 3;

  // reset values
  localparam logic [7:0] MCS_CTRL_RESET = 8'h00;
  localparam logic [7:0] MCS_STSEL_RESET = 8'h80;
  localparam logic [7:0] MCS_WAKE_RESET = 8'h04;

  // switching clock timing
  localparam int MCS_CLK_FREQ_KHZ = 40000;
  localparam int MCS_SW_FREQ_KHZ = 400;
  localparam int MCS_SW_DITHER_PCT = 7;
  localparam logic [7:0] MCS_SW_PERIOD_CYC = 8'(MCS_CLK_FREQ_KHZ / MCS_SW_FREQ_KHZ);
  localparam logic [7:0] MCS_SW_DITHER_CYC =
    8'((MCS_CLK_FREQ_KHZ / MCS_SW_FREQ_KHZ) * MCS_SW_DITHER_PCT / 100);

  // operating modes, gray coded along shutdown-standby-charge-boost-health
  typedef enum logic [2:0] {
    MCS_MODE_SHUTDOWN = 3'h0,
    MCS_MODE_STANDBY = 3'h1,
    MCS_MODE_CHARGE = 3'h3,
    MCS_MODE_BOOST = 3'h2,
    MCS_MODE_HEALTH = 3'h6,
    MCS_MODE_THERMAL = 3'h4
  } mcs_mode_e;

endpackage : mcs_pkg

// file: core/mcs_swclk_if.sv
// switching clock control bundle between mode control and the clock generator
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface mcs_swclk_if;
  logic run;
  logic spread_en;
  logic sw_clk;
  modport ctrl (output run, output spread_en, input sw_clk);
  modport gen (input run, input spread_en, output sw_clk);
endinterface : mcs_swclk_if
`default_nettype wire

// file: core/mcs_swclk_gen.sv
// switching clock generator with optional period dither
// assumes run and spread_en are synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module mcs_swclk_gen
  import mcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  mcs_swclk_if.gen sw
);

  logic [7:0] cnt_r;
  logic [7:0] period_r;
  logic [7:0] period_nxt;
  logic [3:0] lfsr_r;
  logic clk_r;

  // lfsr runs 1..15, so the offset spans -dither..+dither around nominal
  always_comb begin
    if (sw.spread_en) begin
      period_nxt = 8'(MCS_SW_PERIOD_CYC + {4'h0, lfsr_r} - MCS_SW_DITHER_CYC - 8'h01);
    end else begin
      period_nxt = MCS_SW_PERIOD_CYC;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      period_r <= MCS_SW_PERIOD_CYC;
      lfsr_r <= 4'h1;
    end else if (!sw.run) begin
      cnt_r <= 8'h00;
      period_r <= MCS_SW_PERIOD_CYC;
    end else if (cnt_r >= period_r - 8'h01) begin
      cnt_r <= 8'h00;
      period_r <= period_nxt;
      lfsr_r <= {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_r <= 1'b0;
    end else begin
      clk_r <= sw.run && (cnt_r < {1'b0, period_r[7:1]});
    end
  end

  assign sw.sw_clk = clk_r;

endmodule : mcs_swclk_gen
`default_nettype wire

// file: test/mcs_mode_ctrl_chk.sv
// checker: port assertions for the mode control block
// assumes binding onto mcs_mode_ctrl, one clock domain
`timescale 1ns/100ps
`default_nettype none
module mcs_mode_ctrl_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic BOOST_ENABLE_PIN,
  input wire logic CHARGE_ENABLE_PIN,
  input wire logic SUPPLY_OK,
  input wire logic BACKUP_UVLO_OK,
  input wire logic OUTPUT_UVLO_OK,
  input wire logic VOUT_BELOW_WAKE,
  input wire logic VOUT_ABOVE_STANDBY,
  input wire logic THERMAL_TRIP_CMP,
  input wire logic THERMISTOR_HOT,
  input wire logic THERMISTOR_COLD,
  input wire logic I2C_ACTIVE,
  input wire logic BOOST_ON,
  input wire logic CHARGER_ON,
  input wire logic HEALTH_ON,
  input wire logic STATUS_OUT,
  input wire logic STATUS_OE_N
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_off;
    !BOOST_ON && !CHARGER_ON && !HEALTH_ON;
  endsequence
  sequence s_leave;
    BOOST_ON && VOUT_ABOVE_STANDBY && !VOUT_BELOW_WAKE;
  endsequence
  property p_sd;
    !BOOST_ENABLE_PIN && !CHARGE_ENABLE_PIN |=> s_off;
  endproperty
  a_sd: assert property (p_sd) else $error("function on with pins low");
  property p_i2c;
    1'b1 |=> I2C_ACTIVE == $past(BOOST_ENABLE_PIN || CHARGE_ENABLE_PIN);
  endproperty
  a_i2c: assert property (p_i2c) else $error("bus access flag wrong");
  property p_bpin;
    BOOST_ON |-> $past(BOOST_ENABLE_PIN);
  endproperty
  a_bpin: assert property (p_bpin) else $error("boost without pin");
  property p_chg;
    CHARGER_ON |-> $past(CHARGE_ENABLE_PIN && OUTPUT_UVLO_OK && !THERMISTOR_HOT && !THERMISTOR_COLD);
  endproperty
  a_chg: assert property (p_chg) else $error("charger on wrongly");
  property p_hlt;
    HEALTH_ON |-> $past(CHARGE_ENABLE_PIN && OUTPUT_UVLO_OK);
  endproperty
  a_hlt: assert property (p_hlt) else $error("health on wrongly");
  property p_bat;
    BOOST_ON |-> $past(BACKUP_UVLO_OK && SUPPLY_OK);
  endproperty
  a_bat: assert property (p_bat) else $error("boost under lockout");
  property p_trip;
    THERMAL_TRIP_CMP |=> s_off;
  endproperty
  a_trip: assert property (p_trip) else $error("switch on in thermal trip");
  property p_wake;
    $rose(BOOST_ON) |-> $past(VOUT_BELOW_WAKE);
  endproperty
  a_wake: assert property (p_wake) else $error("boost entered above wake");
  property p_leave;
    s_leave |=> !BOOST_ON;
  endproperty
  a_leave: assert property (p_leave) else $error("boost kept above target");
  property p_od;
    STATUS_OUT == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("status drives high");
  property p_rel;
    !BOOST_ENABLE_PIN && !CHARGE_ENABLE_PIN |-> ##2 STATUS_OE_N;
  endproperty
  a_rel: assert property (p_rel) else $error("status low in shutdown");
endmodule : mcs_mode_ctrl_chk
bind mcs_mode_ctrl mcs_mode_ctrl_chk i_mcs_mode_ctrl_chk (
  .CLK(CLK), .RESETN(RESETN), .BOOST_ENABLE_PIN(BOOST_ENABLE_PIN),
  .CHARGE_ENABLE_PIN(CHARGE_ENABLE_PIN), .SUPPLY_OK(SUPPLY_OK), .BACKUP_UVLO_OK(BACKUP_UVLO_OK),
  .OUTPUT_UVLO_OK(OUTPUT_UVLO_OK), .VOUT_BELOW_WAKE(VOUT_BELOW_WAKE),
  .VOUT_ABOVE_STANDBY(VOUT_ABOVE_STANDBY), .THERMAL_TRIP_CMP(THERMAL_TRIP_CMP),
  .THERMISTOR_HOT(THERMISTOR_HOT), .THERMISTOR_COLD(THERMISTOR_COLD), .I2C_ACTIVE(I2C_ACTIVE),
  .BOOST_ON(BOOST_ON), .CHARGER_ON(CHARGER_ON), .HEALTH_ON(HEALTH_ON), .STATUS_OUT(STATUS_OUT),
  .STATUS_OE_N(STATUS_OE_N)
);
`default_nettype wire

// file: test/mcs_host.sv
// host model: enable pins and register port accesses
// assumes the device samples on the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module mcs_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic ben,
  output logic cen,
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata
);
  initial begin
    {ben, cen, wr, rd} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic pins(input logic b, input logic c);
    ben = b;
    cen = c;
  endtask : pins
  // released lines show the inverse of the last value
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : wr8
  // a read of the flags register clears sticky alerts
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdata;
    addr = ~a;
  endtask : rd8
endmodule : mcs_host
`default_nettype wire

// file: test/mcs_mode_ctrl_tb.sv
// testbench: mode control scenarios through the host model
// assumes the checker is bound onto the design
`timescale 1ns/100ps
`default_nettype none
module mcs_mode_ctrl_tb;
  import mcs_pkg::*;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic sup = 1'b1, bat = 1'b1, outu = 1'b1, below = 1'b0, above = 1'b1;
  logic trip = 1'b0, hot = 1'b0, cold = 1'b0, done = 1'b0;
  wire logic ben, cen, wr, rd, act, bon, con, hon, sclk, sout, soen;
  wire logic [7:0] addr, wdata, rdata, wake;
  int mismatches = 0;
  int n_checks = 0;
  mcs_host i_mcs_host (.clk(CLK), .rdata(rdata), .ben(ben), .cen(cen), .addr(addr), .wr(wr),
    .rd(rd), .wdata(wdata));
  mcs_mode_ctrl i_mcs_mode_ctrl (.CLK(CLK), .RESETN(RESETN), .BOOST_ENABLE_PIN(ben),
    .CHARGE_ENABLE_PIN(cen), .SUPPLY_OK(sup), .BACKUP_UVLO_OK(bat), .OUTPUT_UVLO_OK(outu),
    .VOUT_BELOW_WAKE(below), .VOUT_ABOVE_STANDBY(above), .THERMAL_TRIP_CMP(trip),
    .THERMISTOR_HOT(hot), .THERMISTOR_COLD(cold), .CHARGE_DONE(done), .REG_ADDR(addr),
    .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .I2C_ACTIVE(act),
    .BOOST_ON(bon), .CHARGER_ON(con), .HEALTH_ON(hon), .BOOST_WAKE_THRESHOLD(wake),
    .SWITCH_CLK(sclk), .STATUS_OUT(sout), .STATUS_OE_N(soen));
  initial begin
    forever #12.5 CLK = ~CLK;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // order: boost, charger, health, status enable low
  task automatic outs(input logic [3:0] e);
    chk(8'({bon, con, hon, soen}), 8'(e));
  endtask : outs
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_mcs_host.rd8(a, d);
    chk(d, e);
  endtask : rdc
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  task automatic t_reset();
    rdc(MCS_WAKE_ADDR, MCS_WAKE_RESET);
    rdc(MCS_CTRL_ADDR, MCS_CTRL_RESET);
    rdc(MCS_STSEL_ADDR, MCS_STSEL_RESET);
    rdc(MCS_FLAGS_ADDR, 8'h01);
    rdc(8'h10, 8'h00);
    chk(8'(act), 8'h01);
    outs(4'h1);
    chk(8'(sclk), 8'h00);
    chk(8'(sout), 8'h00);
  endtask : t_reset
  task automatic t_regs();
    i_mcs_host.wr8(MCS_STSEL_ADDR, 8'hFF);
    rdc(MCS_STSEL_ADDR, 8'hF8);
    i_mcs_host.wr8(MCS_STSEL_ADDR, 8'h80);
    i_mcs_host.wr8(MCS_WAKE_ADDR, 8'h37);
    chk(wake, 8'h37);
  endtask : t_regs
  task automatic t_func();
    for (int i = 1; i < 4; i++) begin
      i_mcs_host.wr8(MCS_CTRL_ADDR, 8'(i << 5));
      tick(3);
      outs({1'b0, i == 1, i == 2, 1'b1});
    end
    i_mcs_host.wr8(MCS_CTRL_ADDR, 8'h20);
    hot = 1'b1;
    tick(3);
    outs(4'h1);
    hot = 1'b0;
    tick(3);
    outs(4'h5);
  endtask : t_func
  task automatic t_boost();
    i_mcs_host.wr8(MCS_CTRL_ADDR, 8'h80);
    above = 1'b0;
    below = 1'b1;
    tick(3);
    outs(4'h8);
    bat = 1'b0;
    tick(3);
    outs(4'h1);
    bat = 1'b1;
    tick(4);
    outs(4'h8);
    i_mcs_host.pins(1'b0, 1'b1);
    tick(3);
    outs(4'h1);
    i_mcs_host.pins(1'b1, 1'b1);
    tick(4);
    below = 1'b0;
    above = 1'b1;
    tick(3);
    outs(4'h1);
    i_mcs_host.wr8(MCS_STSEL_ADDR, 8'h40);
    tick(3);
    outs(4'h0);
    rdc(MCS_FLAGS_ADDR, 8'h41);
    tick(3);
    outs(4'h1);
  endtask : t_boost
  task automatic t_alerts();
    i_mcs_host.wr8(MCS_STSEL_ADDR, 8'h20);
    done = 1'b1;
    tick(1);
    done = 1'b0;
    tick(3);
    outs(4'h0);
    rdc(MCS_FLAGS_ADDR, 8'h21);
    tick(3);
    outs(4'h1);
    i_mcs_host.wr8(MCS_STSEL_ADDR, 8'h18);
    above = 1'b0;
    below = 1'b1;
    tick(3);
    trip = 1'b1;
    tick(3);
    outs(4'h0);
    trip = 1'b0;
    tick(4);
    outs(4'h9);
    below = 1'b0;
    above = 1'b1;
    cold = 1'b1;
    tick(3);
    outs(4'h0);
    cold = 1'b0;
  endtask : t_alerts
  // cycles between two rising edges of the switching clock, 0 if none within the bound
  task automatic swp(output int p);
    int r0;
    logic last;
    p = 0;
    r0 = -1;
    last = sclk;
    for (int k = 0; k < 400 && p == 0; k++) begin
      tick(1);
      if (sclk && !last && r0 >= 0) begin
        p = k - r0;
      end else if (sclk && !last) begin
        r0 = k;
      end
      last = sclk;
    end
  endtask : swp
  task automatic t_clk();
    int p1;
    int p2;
    int lo;
    int hi;
    lo = MCS_SW_PERIOD_CYC - MCS_SW_DITHER_CYC;
    hi = MCS_SW_PERIOD_CYC + MCS_SW_DITHER_CYC;
    i_mcs_host.wr8(MCS_CTRL_ADDR, 8'h80);
    above = 1'b0;
    below = 1'b1;
    swp(p1);
    chk(8'(p1), MCS_SW_PERIOD_CYC);
    i_mcs_host.wr8(MCS_CTRL_ADDR, 8'h90);
    swp(p1);
    swp(p1);
    swp(p2);
    chk(8'(p1 >= lo && p1 <= hi), 8'h01);
    chk(8'(p2 >= lo && p2 <= hi), 8'h01);
    chk(8'(p1 != p2), 8'h01);
    below = 1'b0;
    above = 1'b1;
    tick(3);
    chk(8'(sclk), 8'h00);
  endtask : t_clk
  task automatic t_shut();
    i_mcs_host.pins(1'b0, 1'b0);
    tick(3);
    chk(8'(act), 8'h00);
    i_mcs_host.pins(1'b1, 1'b1);
    tick(3);
    rdc(MCS_STSEL_ADDR, MCS_STSEL_RESET);
    rdc(MCS_CTRL_ADDR, MCS_CTRL_RESET);
  endtask : t_shut
  task automatic t_supply();
    i_mcs_host.wr8(MCS_CTRL_ADDR, 8'h20);
    tick(2);
    rdc(MCS_FLAGS_ADDR, 8'h03);
    outu = 1'b0;
    tick(3);
    outs(4'h1);
    outu = 1'b1;
    sup = 1'b0;
    tick(3);
    outs(4'h1);
    rdc(MCS_FLAGS_ADDR, 8'h00);
    sup = 1'b1;
    i_mcs_host.wr8(MCS_CTRL_ADDR, 8'h40);
    tick(2);
    rdc(MCS_FLAGS_ADDR, 8'h06);
    trip = 1'b1;
    tick(2);
    rdc(MCS_FLAGS_ADDR, 8'h14);
    trip = 1'b0;
    RESETN = 1'b0;
    tick(2);
    RESETN = 1'b1;
    tick(3);
    outs(4'h1);
    rdc(MCS_CTRL_ADDR, MCS_CTRL_RESET);
  endtask : t_supply
  initial begin
    #(25 * 20000);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge CLK);
    #1;
    RESETN = 1'b1;
    i_mcs_host.pins(1'b1, 1'b1);
    tick(3);
    t_reset();
    t_regs();
    t_func();
    t_boost();
    t_alerts();
    t_clk();
    t_shut();
    t_supply();
    print_verdict();
  end
endmodule : mcs_mode_ctrl_tb
`default_nettype wire
